/* include/elink_consts.svh */
`ifndef ELINK_CONSTS_SVH
`define ELINK_CONSTS_SVH

// Register byte addresses
`define REG_CTRL_ADDR 4'h0
`define REG_STATUS_ADDR 4'h4
`define REG_ADDR_W 4

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_FMT_LSB 4
`define CTRL_FMT_MSB 6
`define CTRL_DLY_LSB 8
`define CTRL_DLY_MSB 11
`define CTRL_W 12
`define CTRL_RESET 12'h000
`define CTRL_BYTE0_MSB 7
`define CTRL_BYTE1_LSB 8

// Status register fields
`define STAT_LANE_LSB 0
`define STAT_LANE_MSB 7
`define STAT_VEC_LSB 8
`define STAT_VEC_MSB 17
`define STAT_TP_BIT 18

// Timing figures
`define BC_PERIOD_NS 25
`define SYS_PERIOD_NS 25
`define TP_STRETCH_BC 32
`define TP_CNT_W 6
`define DLY_MAX_BC 15
`define DLY_DEPTH 16
`define DLY_W 4
`define LANE_W 8
`define LANE_ZERO 8'h00

`endif

/* include/timing_pkg.sv */
package timing_pkg;

  // Decoded timing bits, highest bit first; level1_accept is the lowest bit of the vector
  typedef struct packed {
    logic [1:0] broadcast_type_bits;
    logic [3:0] user_broadcast_bits;
    logic event_count_reset;
    logic bunch_count_reset;
    logic b_channel;
    logic level1_accept;
  } timing_bits_t;

  // Output format codes; implicit values equal the option numbers
  typedef enum logic [2:0] {
    FMT_TWO_BCHAN,
    FMT_FOUR_BASIC,
    FMT_EIGHT_FULL,
    FMT_EIGHT_READOUT,
    FMT_FOUR_BCR_WIDE,
    FMT_TWO_BCR_HALF,
    FMT_UNUSED6,
    FMT_UNUSED7
  } format_t;

  // Avalon-MM slave request and answer
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avmm_rsp_t;

endpackage

/* hw/timing_bit_elink_encoder.sv */
`timescale 1ns/10ps
`include "elink_consts.svh"
//
// Overview of operation
// - Every bunch crossing a fresh selected bit set reaches the lane, fixed latency.
// - No stream handshake or FIFO; input is the decoded timing vector.
// - Bits per crossing are two, four or eight, matching lane width.
// - Whole timing vector is delayed zero to fifteen crossings before encoding.
// - Test pulse is lowest user broadcast bit stretched to 32 crossings.
// - Lane bit zero is sent first, higher positions follow in order.
// - Formats 0, 1 and 2 map B-channel and accept; 1 and 2 add both resets, 2 adds broadcasts.
// - Format 3 maps accept, broadcasts, test pulse, resets and level-0 accept.
// - Format 4 drives bunch reset on all four bits.
// - Format 5 sends bunch reset on bit 1, its delayed copy on bit 0.
// - Orbit reset follows bunch reset by one crossing, lasting two crossings when type bit 1 set.
// - Level-0 accept is a copy of level-1 accept.
// - Delayed bunch reset is bunch reset delayed by exactly one crossing.
// - Broadcast bits pass as single-crossing strobes, except user bit 0, stretched as the test pulse.
// - Three-bit format code equals the option number directly.
// - Encoder works only while its enable is set.
// - Input to lane latency is one crossing; delayed bunch and orbit resets one more.
// - Input carries accept, B-channel, resets, four user and two type bits.
//
module timing_bit_elink_encoder (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire timing_pkg::avmm_req_t avs_req,
  output timing_pkg::avmm_rsp_t avs_rsp,
  input wire timing_pkg::timing_bits_t timing_bits_in,
  output logic [7:0] lane_bits_out
);
  import timing_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic ack_q;
  logic [`CTRL_W-1:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [`LANE_W-1:0] lane_q;
  logic tp_active;
  timing_bits_t dly_bits;

  wire req_any = avs_req.read | avs_req.write;
  wire req_done = req_any & ack_q;
  wire hit_ctrl = avs_req.address == `REG_CTRL_ADDR;
  wire hit_status = avs_req.address == `REG_STATUS_ADDR;
  wire wr_ctrl = req_done & avs_req.write & hit_ctrl;
  wire wr_lo = wr_ctrl & avs_req.byteenable[0];
  wire wr_hi = wr_ctrl & avs_req.byteenable[1];

  wire [`CTRL_W-1:0] ctrl_d = {
    wr_hi ? avs_req.writedata[`CTRL_W-1:`CTRL_BYTE1_LSB] : ctrl_q[`CTRL_W-1:`CTRL_BYTE1_LSB],
    wr_lo ? avs_req.writedata[`CTRL_BYTE0_MSB:0] : ctrl_q[`CTRL_BYTE0_MSB:0]
  };

  wire enable = ctrl_q[`CTRL_EN_BIT];
  wire format_t format_select = format_t'(ctrl_q[`CTRL_FMT_MSB:`CTRL_FMT_LSB]);
  wire [`DLY_W-1:0] delay_sel = ctrl_q[`CTRL_DLY_MSB:`CTRL_DLY_LSB];

  wire [31:0] status_word = {13'h0000, tp_active, dly_bits, lane_q};

  assign rdata_d = hit_ctrl ? {20'h00000, ctrl_q} : (hit_status ? status_word : 32'h00000000);
  assign avs_rsp.waitrequest = req_any & ~ack_q;
  assign avs_rsp.readdata = rdata_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req_any & ~ack_q;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Delay line

  timing_bits_t dly_mem [`DLY_DEPTH];

  // Bits pass through as strobes; no broadcast is held
  assign dly_bits = (delay_sel == `DLY_W'h0) ? timing_bits_in :
                    dly_mem[delay_sel - `DLY_W'h1];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `DLY_DEPTH; i++) begin
        dly_mem[i] <= '0;
      end
    end else begin
      dly_mem[0] <= timing_bits_in;
      for (int i = 1; i < `DLY_DEPTH; i++) begin
        dly_mem[i] <= dly_mem[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Derived bits

  logic [`TP_CNT_W-1:0] tp_cnt_q;
  logic [`TP_CNT_W-1:0] tp_cnt_d;
  logic bcr_dly_q;
  logic ocr_wide_q;
  logic ocr_second_q;

  // Pulse high on the strobe crossing and the 31 after it
  assign tp_cnt_d = dly_bits.user_broadcast_bits[0] ? `TP_CNT_W'(`TP_STRETCH_BC - 1) :
                    (tp_cnt_q != '0) ? tp_cnt_q - `TP_CNT_W'h1 : tp_cnt_q;
  assign tp_active = dly_bits.user_broadcast_bits[0] | (tp_cnt_q != '0);

  wire delayed_bunch_reset = bcr_dly_q;
  wire orbit_count_reset = bcr_dly_q | ocr_second_q;
  wire level0_accept = dly_bits.level1_accept;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tp_cnt_q <= '0;
      bcr_dly_q <= 1'b0;
      ocr_wide_q <= 1'b0;
      ocr_second_q <= 1'b0;
    end else begin
      tp_cnt_q <= tp_cnt_d;
      bcr_dly_q <= dly_bits.bunch_count_reset;
      ocr_wide_q <= dly_bits.bunch_count_reset & dly_bits.broadcast_type_bits[1];
      ocr_second_q <= ocr_wide_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Format mapping

  // Bit 0 is the first bit on the serial lane
  wire [7:0] map_two = {6'h00, dly_bits.b_channel, dly_bits.level1_accept};
  wire [7:0] map_four = {4'h0, dly_bits.b_channel, dly_bits.event_count_reset,
                         dly_bits.bunch_count_reset, dly_bits.level1_accept};
  wire [7:0] map_eight = {dly_bits.b_channel, dly_bits.user_broadcast_bits,
                          dly_bits.event_count_reset, dly_bits.bunch_count_reset,
                          dly_bits.level1_accept};
  wire [7:0] map_readout = {dly_bits.level1_accept, dly_bits.user_broadcast_bits[1],
                            tp_active, dly_bits.event_count_reset, orbit_count_reset,
                            level0_accept, dly_bits.user_broadcast_bits[3],
                            dly_bits.user_broadcast_bits[2]};
  wire [7:0] map_bcr_wide = {4'h0, {4{dly_bits.bunch_count_reset}}};
  wire [7:0] map_bcr_half = {6'h00, dly_bits.bunch_count_reset, delayed_bunch_reset};

  logic [`LANE_W-1:0] lane_d;

  always_comb begin
    case (format_select)
      FMT_TWO_BCHAN: lane_d = map_two;
      FMT_FOUR_BASIC: lane_d = map_four;
      FMT_EIGHT_FULL: lane_d = map_eight;
      FMT_EIGHT_READOUT: lane_d = map_readout;
      FMT_FOUR_BCR_WIDE: lane_d = map_bcr_wide;
      FMT_TWO_BCR_HALF: lane_d = map_bcr_half;
      default: lane_d = `LANE_ZERO;
    endcase
    if (!enable) begin
      lane_d = `LANE_ZERO;
    end
  end

  // One register stage from input to lane, every crossing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lane_q <= `LANE_ZERO;
    end else begin
      lane_q <= lane_d;
    end
  end

  assign lane_bits_out = lane_q;

endmodule

/* test/lane_receiver.sv */
`timescale 1ns/10ps
module lane_receiver (
  input wire logic sys_clk,
  input wire logic [7:0] lane_bits_out,
  input wire logic [2:0] lane_w,
  output logic b_chan_rx
);
  // B-channel is the last serial bit of the word, one bit per crossing
  always_ff @(posedge sys_clk) begin
    b_chan_rx <= lane_bits_out[lane_w - 3'h1];
  end
endmodule

/* test/elink_enc_assertions.sv */
`timescale 1ns/10ps
module elink_enc_assertions (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire timing_pkg::avmm_req_t avs_req,
  input wire timing_pkg::avmm_rsp_t avs_rsp,
  input wire timing_pkg::timing_bits_t timing_bits_in,
  input wire logic [7:0] lane_bits_out
);
  import timing_pkg::*;
  logic [11:0] ctrl_q;
  logic [5:0] age_q;
  logic [5:0] tp_q;
  wire req = avs_req.read | avs_req.write;
  wire wr0 = avs_req.write & ~avs_rsp.waitrequest & (avs_req.address == 4'h0);
  wire [2:0] fmt = ctrl_q[6:4];
  wire go = ctrl_q[0] & (ctrl_q[11:8] == 4'h0);
  wire [7:0] msk = (go && fmt == 3'h3) ? 8'hD7 : (go && fmt == 3'h5) ? 8'hFC : 8'hFF;
  wire [2:0] efmt = ctrl_q[0] ? fmt : 3'h7;
  // Direct bits only; derived bits are masked out
  function automatic logic [7:0] exp_f(logic [2:0] m, logic [9:0] v);
    case (m)
      3'h0: exp_f = {6'h00, v[1:0]};
      3'h1: exp_f = {4'h0, v[1], v[3], v[2], v[0]};
      3'h2: exp_f = {v[1], v[7:4], v[3:2], v[0]};
      3'h3: exp_f = {v[0], v[5], 1'b0, v[3], 1'b0, v[0], v[7:6]};
      3'h4: exp_f = {4'h0, {4{v[2]}}};
      default: exp_f = 8'h00;
    endcase
  endfunction
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= 12'h000;
      age_q <= 6'h00;
      tp_q <= 6'h00;
    end else begin
      if (wr0 && avs_req.byteenable[0]) ctrl_q[7:0] <= avs_req.writedata[7:0];
      if (wr0 && avs_req.byteenable[1]) ctrl_q[11:8] <= avs_req.writedata[11:8];
      age_q <= wr0 ? 6'h00 : age_q + {5'h00, age_q != 6'h3F};
      tp_q <= timing_bits_in[4] ? 6'h20 : tp_q - {5'h00, tp_q != 6'h00};
    end
  end
  a_wait_first: assert property (@(posedge sys_clk) disable iff (!nrst)
    req && !$past(req) |-> avs_rsp.waitrequest) else $error("no wait state");
  a_wait_one: assert property (@(posedge sys_clk) disable iff (!nrst)
    req && avs_rsp.waitrequest |=> !avs_rsp.waitrequest) else $error("wait too long");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    avs_req.read && !avs_rsp.waitrequest && avs_req.address != 4'h0 &&
    avs_req.address != 4'h4 |->
    avs_rsp.readdata == 32'h0) else $error("unmapped read");
  a_map_direct: assert property (@(posedge sys_clk) disable iff (!nrst)
    age_q >= 6'h01 && (go || !ctrl_q[0]) |=>
    (lane_bits_out & $past(msk)) == $past(exp_f(efmt, timing_bits_in))) else $error("bad lane");
  a_bcr_half: assert property (@(posedge sys_clk) disable iff (!nrst)
    age_q >= 6'h02 && go && fmt == 3'h5 |=> lane_bits_out[1:0] ==
    {$past(timing_bits_in[2]), $past(timing_bits_in[2], 2)}) else $error("bad half");
  a_orbit_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
    age_q >= 6'h03 && go && fmt == 3'h3 |=> lane_bits_out[3] == ($past(timing_bits_in[2], 2)
    || ($past(timing_bits_in[2], 3) && $past(timing_bits_in[9], 3)))) else $error("bad orbit");
  a_test_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    age_q >= 6'h22 && go && fmt == 3'h3 |=> lane_bits_out[5] == (tp_q != 6'h00))
    else $error("bad pulse");
  a_delay_line: assert property (@(posedge sys_clk) disable iff (!nrst)
    age_q >= 6'h11 && ctrl_q[11:8] == 4'hF && ctrl_q[0] && fmt == 3'h2 |=>
    lane_bits_out == $past(exp_f(3'h2, timing_bits_in), 16)) else $error("bad delay");
endmodule
bind timing_bit_elink_encoder elink_enc_assertions chk (.sys_clk(sys_clk), .nrst(nrst),
  .avs_req(avs_req), .avs_rsp(avs_rsp), .timing_bits_in(timing_bits_in),
  .lane_bits_out(lane_bits_out));

/* test/timing_bit_elink_encoder_test.sv */
`timescale 1ns/10ps
module timing_bit_elink_encoder_test;
  import timing_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  avmm_req_t req = '0;
  avmm_rsp_t rsp;
  timing_bits_t tin = '0;
  logic [7:0] lane;
  logic rx_b;
  logic [31:0] q;
  int failures = 0;
  int comparisons = 0;
  int n;
  // Three successive lane words per format; entry 8 is format 2 disabled
  localparam logic [23:0] EXP [9] = '{24'h010000, 24'h030000, 24'h4B0000, 24'hA62828,
    24'h0F0000, 24'h020100, 24'h000000, 24'h000000, 24'h000000};
  always #12.5 sys_clk = ~sys_clk;
  timing_bit_elink_encoder dut (.sys_clk(sys_clk), .nrst(nrst), .avs_req(req),
    .avs_rsp(rsp), .timing_bits_in(tin), .lane_bits_out(lane));
  lane_receiver rx (.sys_clk(sys_clk), .lane_bits_out(lane), .lane_w(3'h2), .b_chan_rx(rx_b));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    req <= '{read: rd, write: !rd, address: a, writedata: wd, byteenable: 4'hF};
    do @(posedge sys_clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req <= '0;
  endtask
  task automatic wctl(input logic en, input logic [2:0] f, input logic [3:0] d);
    bus(1'b0, 4'h0, {20'h0, d, 1'b0, f, 3'h0, en});
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    @(posedge sys_clk) tin <= 10'h295;
    wctl(1'b1, 3'h5, 4'h9);
    bus(1'b1, 4'h8, 32'h0);
    check(q, 32'h0);
    bus(1'b0, 4'hC, 32'hFFF);
    bus(1'b1, 4'h0, 32'h0);
    check(q & 32'hF71, 32'h951);
    bus(1'b1, 4'h4, 32'h0);
    check(q, 32'h00069503);
    tin <= '0;
    $display("regs done");
  endtask
  task automatic t_formats;
    for (int i = 0; i < 9; i++) begin
      wctl(i != 8, (i == 8) ? 3'h2 : 3'(i), 4'h0);
      @(posedge sys_clk) tin <= 10'h295;
      for (int c = 2; c >= 0; c--) begin
        @(posedge sys_clk) tin <= '0;
        #1 check(lane, EXP[i][8*c +: 8]);
      end
    end
    $display("formats done");
  endtask
  task automatic t_bchan;
    wctl(1'b1, 3'h0, 4'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk) tin <= {8'h00, k[0] ^ k[1], 1'b0};
      @(posedge sys_clk) tin <= '0;
      @(posedge sys_clk) #1 check(rx_b, k[0] ^ k[1]);
    end
    $display("bchan done");
  endtask
  task automatic t_stretch;
    wctl(1'b1, 3'h3, 4'h0);
    repeat (40) @(posedge sys_clk);
    @(posedge sys_clk) tin <= 10'h010;
    @(posedge sys_clk) tin <= '0;
    n = 0;
    repeat (40) begin
      #1 n += (lane[5] === 1'b1);
      @(posedge sys_clk);
    end
    check(n, 32);
    $display("stretch done");
  endtask
  task automatic t_delay;
    wctl(1'b1, 3'h2, 4'hF);
    repeat (20) @(posedge sys_clk);
    @(posedge sys_clk) tin <= 10'h295;
    n = 0;
    do begin
      @(posedge sys_clk) tin <= '0;
      #1 n++;
    end while (lane === 8'h00 && n < 30);
    check(n, 16);
    check(lane, 8'h4B);
    $display("delay done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_formats;
    t_bchan;
    t_stretch;
    t_delay;
    stop_test;
  end
  initial begin
    #200000;
    failures++;
    stop_test;
  end
endmodule
